// [src/flash_cmd_map.svh]
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH

// Command opcodes and the confirmation byte.
`define OP_ULTRA_SLEEP      8'h79
`define OP_DEEP_SLEEP       8'hb9
`define OP_RESUME           8'hab
`define OP_RESET_ENABLE     8'h66
`define OP_RESET_DEVICE     8'h99
`define OP_ABORT            8'hf0
`define ABORT_CONFIRM       8'hd0

// Serial framing.
`define BITS_PER_BYTE       8

// Core clock period and internal delays, in nanoseconds.
`define CORE_CLK_PERIOD_NS  8
`define ULTRA_ENTRY_DELAY_NS  3000
`define ULTRA_RESUME_DELAY_NS 70000
`define SOFT_RESET_DELAY_NS   30000
`define ABORT_DELAY_NS        20000

// Host timing, in core clock cycles.
`define HOST_CS_GAP_CYC     8'h08

// Reset values.
`define LINK_BYTE_RST       8'h00

`endif

// [src/flash_cmd_pkg.sv]
package flash_cmd_pkg;

    typedef enum logic [6:0] {
        ST_STANDBY    = 7'b0000001,
        ST_ENTER_UDS  = 7'b0000010,
        ST_ULTRA      = 7'b0000100,
        ST_DEEP       = 7'b0001000,
        ST_RESUME     = 7'b0010000,
        ST_SOFT_RESET = 7'b0100000,
        ST_ABORT      = 7'b1000000
    } dev_state_e;

    typedef enum logic [2:0] {
        HS_IDLE  = 3'b001,
        HS_SHIFT = 3'b010,
        HS_GAP   = 3'b100
    } host_state_e;

    typedef struct packed {
        logic [2:0] bit_cnt;
        logic [1:0] byte_cnt;
        logic [7:0] shreg;
        logic [7:0] opcode;
        logic [7:0] confirm;
    } link_s;

    typedef struct packed {
        dev_state_e  state;
        logic [31:0] cnt;
        logic        cs_prev;
        logic        reset_armed;
        logic        reinit;
        logic        abort_pe;
        logic        pass_valid;
        logic [7:0]  pass_opcode;
    } core_s;

    typedef struct packed {
        host_state_e state;
        logic [15:0] shreg;
        logic [4:0]  left;
        logic        phase;
        logic        cs_n;
        logic        sclk;
        logic        si;
        logic [7:0]  gap;
        logic        done;
    } host_s;

endpackage : flash_cmd_pkg

// [src/spi_link_if.sv]
`timescale 1ns/1ps
interface spi_link_if;
    logic cs_n;
    logic sclk;
    logic si;

    modport dev  (input  cs_n, input  sclk, input  si);
    modport host (output cs_n, output sclk, output si);
endinterface : spi_link_if

// [src/sync_2ff.sv]
`timescale 1ns/1ps
module sync_2ff #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic [1:0] sync_q;

    // Only the second stage is visible outside.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_q <= {2{RST_VAL}};
        end else begin
            sync_q <= {sync_q[0], d_i};
        end
    end

    assign q_o = sync_q[1];
endmodule : sync_2ff

// [src/flash_powerdown_reset_terminate.sv]
`timescale 1ns/1ps
`include "flash_cmd_map.svh"

// Functional notes
// - Opcodes shift in MSB first, eight clocks
// - Resume from ultra sleep reinitializes, SRAM lost
// - Ultra sleep exit completes within resume delay
// - Resume and reset need whole bytes framed
// - Ultra sleep on 79h, or B9h with select clear
// - Ultra sleep ignores everything except resume opcode
// - Ultra entry after delay; trailing whole bytes ignored
// - Off-boundary ultra entry aborts to standby
// - Power-up lands in standby
// - 79h ignored while program or erase busy
// - Reset needs 66h frame then 99h frame
// - Valid reset reinitializes after reset delay
// - No commands accepted during reset or abort
// - Host checks busy and suspended before reset
// - F0h aborts program or erase, ignores write latch
// - F0h ignored unless abort allow bit set
// - F0h needs D0h confirmation, else discarded
// - Abort begins within abort delay after frame
// - Abort leaves volatile configuration untouched
// - Off-boundary abort frame returns to standby
// - B9h with select set enters deep sleep
module flash_powerdown_reset_terminate #(
    parameter int ULTRA_ENTRY_DELAY_NS  = `ULTRA_ENTRY_DELAY_NS,
    parameter int ULTRA_RESUME_DELAY_NS = `ULTRA_RESUME_DELAY_NS,
    parameter int SOFT_RESET_DELAY_NS   = `SOFT_RESET_DELAY_NS,
    parameter int ABORT_DELAY_NS        = `ABORT_DELAY_NS
) (
    input  wire logic  CORE_CLK_I,
    input  wire logic  RST_N_I,
    spi_link_if.dev    LINK,
    input  wire logic  DEEP_SLEEP_SELECT_I,
    input  wire logic  ABORT_CMD_ALLOW_I,
    input  wire logic  PROG_BUSY_I,
    output logic       ULTRA_DEEP_SLEEP_O,
    output logic       DEEP_SLEEP_O,
    output logic       BUSY_FLAG_O,
    output logic       REINIT_O,
    output logic       ABORT_PE_O,
    output logic       PASS_VALID_O,
    output logic [7:0] PASS_OPCODE_O
);

    // Least time rounds up to whole cycles, never below one.
    function automatic logic [31:0] delay_cycles(input int ns);
        int c;
        c = (ns + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS;
        if (c < 1) begin
            c = 1;
        end
        return 32'(c);
    endfunction : delay_cycles

    localparam logic [31:0] ENTRY_CYC  = delay_cycles(ULTRA_ENTRY_DELAY_NS);
    localparam logic [31:0] RESUME_CYC = delay_cycles(ULTRA_RESUME_DELAY_NS);
    localparam logic [31:0] RESET_CYC  = delay_cycles(SOFT_RESET_DELAY_NS);
    localparam logic [31:0] ABORT_CYC  = delay_cycles(ABORT_DELAY_NS);

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain: bit shifting on the serial clock.

    flash_cmd_pkg::link_s lk_q;
    flash_cmd_pkg::link_s lk_d;
    logic                 in_frame_q;
    logic                 frame_clr_n;

    // The serial clock stops between frames, so the first edge of a frame is
    // recognised by a flag that chip select clears asynchronously.
    assign frame_clr_n = RST_N_I & ~LINK.cs_n;

    always_ff @(posedge LINK.sclk or negedge frame_clr_n) begin
        if (!frame_clr_n) begin
            in_frame_q <= 1'b0;
        end else begin
            in_frame_q <= 1'b1;
        end
    end

    always_comb begin
        lk_d = lk_q;
        if (!in_frame_q) begin
            lk_d.bit_cnt  = 3'h0;
            lk_d.byte_cnt = 2'h0;
            lk_d.shreg    = `LINK_BYTE_RST;
        end
        lk_d.shreg   = {lk_d.shreg[6:0], LINK.si};
        lk_d.bit_cnt = lk_d.bit_cnt + 3'h1;
        if (lk_d.bit_cnt == 3'h0) begin
            if (lk_d.byte_cnt == 2'h0) begin
                lk_d.opcode = lk_d.shreg;
            end else if (lk_d.byte_cnt == 2'h1) begin
                lk_d.confirm = lk_d.shreg;
            end
            if (lk_d.byte_cnt != 2'h3) begin
                lk_d.byte_cnt = lk_d.byte_cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge LINK.sclk or negedge RST_N_I) begin
        if (!RST_N_I) begin
            lk_q <= '{3'h0, 2'h0, `LINK_BYTE_RST, `LINK_BYTE_RST, `LINK_BYTE_RST};
        end else begin
            lk_q <= lk_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Core domain: frame decode and timed operations.

    flash_cmd_pkg::core_s q;
    flash_cmd_pkg::core_s d;
    logic                 cs_sync;
    logic                 frame_end;
    logic                 whole_bytes;
    logic                 confirmed;

    // The link words are quiet once chip select is high, so they are read
    // only after the synchronised deassertion, two or more edges later.
    sync_2ff #(.RST_VAL(1'b1)) u_cs_sync (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (RST_N_I),
        .d_i     (LINK.cs_n),
        .q_o     (cs_sync)
    );

    assign frame_end   = cs_sync & ~q.cs_prev;
    assign whole_bytes = (lk_q.bit_cnt == 3'h0) && (lk_q.byte_cnt != 2'h0);
    assign confirmed   = (lk_q.byte_cnt >= 2'h2) && (lk_q.confirm == `ABORT_CONFIRM);

    always_comb begin
        d            = q;
        d.cs_prev    = cs_sync;
        d.reinit     = 1'b0;
        d.abort_pe   = 1'b0;
        d.pass_valid = 1'b0;
        if (q.cnt != 32'h0) begin
            d.cnt = q.cnt - 32'h1;
        end
        unique case (q.state)
            flash_cmd_pkg::ST_STANDBY: begin
                if (frame_end) begin
                    // A ragged frame is dropped whole and breaks the reset pair.
                    d.reset_armed = 1'b0;
                    if (whole_bytes) begin
                        unique case (lk_q.opcode)
                            `OP_ULTRA_SLEEP: begin
                                if (!PROG_BUSY_I) begin
                                    d.state = flash_cmd_pkg::ST_ENTER_UDS;
                                    d.cnt   = ENTRY_CYC;
                                end
                            end
                            `OP_DEEP_SLEEP: begin
                                if (!PROG_BUSY_I && DEEP_SLEEP_SELECT_I) begin
                                    d.state = flash_cmd_pkg::ST_DEEP;
                                end else if (!PROG_BUSY_I) begin
                                    d.state = flash_cmd_pkg::ST_ENTER_UDS;
                                    d.cnt   = ENTRY_CYC;
                                end
                            end
                            `OP_RESET_ENABLE: begin
                                d.reset_armed = 1'b1;
                            end
                            `OP_RESET_DEVICE: begin
                                if (q.reset_armed) begin
                                    d.state = flash_cmd_pkg::ST_SOFT_RESET;
                                    d.cnt   = RESET_CYC;
                                end
                            end
                            `OP_ABORT: begin
                                // The write latch plays no part here.
                                if (ABORT_CMD_ALLOW_I && confirmed) begin
                                    d.state = flash_cmd_pkg::ST_ABORT;
                                    d.cnt   = ABORT_CYC;
                                end
                            end
                            default: begin
                                d.pass_valid  = 1'b1;
                                d.pass_opcode = lk_q.opcode;
                            end
                        endcase
                    end
                end
            end
            flash_cmd_pkg::ST_ENTER_UDS: begin
                if (q.cnt == 32'h1) begin
                    d.state = flash_cmd_pkg::ST_ULTRA;
                end
            end
            flash_cmd_pkg::ST_ULTRA: begin
                if (frame_end && whole_bytes && lk_q.opcode == `OP_RESUME) begin
                    d.state  = flash_cmd_pkg::ST_RESUME;
                    d.cnt    = RESUME_CYC;
                    d.reinit = 1'b1;
                end
            end
            flash_cmd_pkg::ST_DEEP: begin
                if (frame_end) begin
                    d.reset_armed = 1'b0;
                    if (whole_bytes && lk_q.opcode == `OP_RESUME) begin
                        d.state = flash_cmd_pkg::ST_STANDBY;
                    end else if (whole_bytes && lk_q.opcode == `OP_RESET_ENABLE) begin
                        d.reset_armed = 1'b1;
                    end else if (whole_bytes && lk_q.opcode == `OP_RESET_DEVICE
                                 && q.reset_armed) begin
                        d.state = flash_cmd_pkg::ST_SOFT_RESET;
                        d.cnt   = RESET_CYC;
                    end
                end
            end
            flash_cmd_pkg::ST_RESUME: begin
                if (q.cnt == 32'h1) begin
                    d.state = flash_cmd_pkg::ST_STANDBY;
                end
            end
            flash_cmd_pkg::ST_SOFT_RESET: begin
                // Frames arriving now are simply never decoded.
                if (q.cnt == 32'h1) begin
                    d.state       = flash_cmd_pkg::ST_STANDBY;
                    d.reinit      = 1'b1;
                    d.reset_armed = 1'b0;
                end
            end
            flash_cmd_pkg::ST_ABORT: begin
                if (q.cnt == 32'h1) begin
                    d.state    = flash_cmd_pkg::ST_STANDBY;
                    d.abort_pe = 1'b1;
                end
            end
            default: begin
                d.state = flash_cmd_pkg::ST_STANDBY;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            q <= '{flash_cmd_pkg::ST_STANDBY, 32'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0,
                   8'h00};
        end else begin
            q <= d;
        end
    end

    assign ULTRA_DEEP_SLEEP_O = (q.state == flash_cmd_pkg::ST_ULTRA);
    assign DEEP_SLEEP_O       = (q.state == flash_cmd_pkg::ST_DEEP);
    assign BUSY_FLAG_O        = (q.state == flash_cmd_pkg::ST_ENTER_UDS)
                              | (q.state == flash_cmd_pkg::ST_RESUME)
                              | (q.state == flash_cmd_pkg::ST_SOFT_RESET)
                              | (q.state == flash_cmd_pkg::ST_ABORT);
    assign REINIT_O           = q.reinit;
    assign ABORT_PE_O         = q.abort_pe;
    assign PASS_VALID_O       = q.pass_valid;
    assign PASS_OPCODE_O      = q.pass_opcode;

endmodule : flash_powerdown_reset_terminate

// [src/spi_cmd_host.sv]
`timescale 1ns/1ps
`include "flash_cmd_map.svh"

module spi_cmd_host #(
    parameter logic [7:0] CS_GAP_CYC = `HOST_CS_GAP_CYC
) (
    input  wire logic        CORE_CLK_I,
    input  wire logic        RST_N_I,
    spi_link_if.host         LINK,
    input  wire logic        CMD_VALID_I,
    output logic             CMD_READY_O,
    input  wire logic [15:0] CMD_DATA_I,
    input  wire logic [4:0]  CMD_NBITS_I,
    input  wire logic        BUSY_FLAG_I,
    input  wire logic        SUSPENDED_FLAG_I,
    output logic             DONE_O
);

    flash_cmd_pkg::host_s q;
    flash_cmd_pkg::host_s d;
    logic [7:0]           op;
    logic                 refuse;

    assign op = CMD_DATA_I[15:8];
    // A power-down request waits for the busy flag; a reset pair must not start
    // over a suspended operation, since that would corrupt the array.
    assign refuse = (BUSY_FLAG_I && (op == `OP_ULTRA_SLEEP || op == `OP_DEEP_SLEEP))
                  | ((BUSY_FLAG_I | SUSPENDED_FLAG_I) && op == `OP_RESET_ENABLE)
                  | (CMD_NBITS_I == 5'h0)
                  | (CMD_NBITS_I > 5'h10);
    assign CMD_READY_O = (q.state == flash_cmd_pkg::HS_IDLE) & ~refuse;

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        d      = q;
        d.done = 1'b0;
        unique case (q.state)
            flash_cmd_pkg::HS_IDLE: begin
                if (CMD_VALID_I && CMD_READY_O) begin
                    d.state = flash_cmd_pkg::HS_SHIFT;
                    d.shreg = CMD_DATA_I;
                    d.left  = CMD_NBITS_I;
                    d.phase = 1'b0;
                    d.cs_n  = 1'b0;
                    d.si    = CMD_DATA_I[15];
                end
            end
            flash_cmd_pkg::HS_SHIFT: begin
                // The serial clock is the core clock halved.
                d.phase = ~q.phase;
                d.sclk  = ~q.phase;
                if (q.phase) begin
                    d.shreg = {q.shreg[14:0], 1'b0};
                    d.si    = q.shreg[14];
                    d.left  = q.left - 5'h1;
                    if (q.left == 5'h1) begin
                        d.state = flash_cmd_pkg::HS_GAP;
                        d.cs_n  = 1'b1;
                        d.si    = 1'b0;
                        d.gap   = CS_GAP_CYC;
                    end
                end
            end
            flash_cmd_pkg::HS_GAP: begin
                d.gap = q.gap - 8'h01;
                if (q.gap <= 8'h01) begin
                    d.state = flash_cmd_pkg::HS_IDLE;
                    d.done  = 1'b1;
                end
            end
            default: begin
                d.state = flash_cmd_pkg::HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            q <= '{flash_cmd_pkg::HS_IDLE, 16'h0000, 5'h00, 1'b0, 1'b1, 1'b0, 1'b0,
                   8'h00, 1'b0};
        end else begin
            q <= d;
        end
    end

    assign LINK.cs_n = q.cs_n;
    assign LINK.sclk = q.sclk;
    assign LINK.si   = q.si;
    assign DONE_O    = q.done;

endmodule : spi_cmd_host

// [verif/flash_link_asserts.sv]
`timescale 1ns/1ps
module flash_link_asserts #(
    parameter int MAX_BUSY_CYC = 52
) (
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic si,
    input wire logic ULTRA_DEEP_SLEEP_O,
    input wire logic DEEP_SLEEP_O,
    input wire logic BUSY_FLAG_O,
    input wire logic REINIT_O,
    input wire logic ABORT_PE_O,
    input wire logic PASS_VALID_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);
    ////////////////////////////////////////////////////////////
    // A saturating count keeps a stuck busy flag from wrapping back into range.
    logic [7:0] busy_run_q;
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) busy_run_q <= 8'h00;
        else if (!BUSY_FLAG_O) busy_run_q <= 8'h00;
        else if (busy_run_q != 8'hff) busy_run_q <= busy_run_q + 8'h01;
    end
    ////////////////////////////////////////////////////////////
    a_sclk_idle_low: assert property (cs_n |-> !sclk)
        else $error("serial clock moved outside a frame");
    a_si_idle_low: assert property (cs_n |-> !si)
        else $error("serial data moved outside a frame");
    a_cs_gap_min: assert property ($rose(cs_n) |-> cs_n [*8])
        else $error("chip select gap too short");
    a_modes_exclusive: assert property (
        !(ULTRA_DEEP_SLEEP_O && (DEEP_SLEEP_O || BUSY_FLAG_O)))
        else $error("sleep modes overlap");
    a_ultra_via_delay: assert property (
        $rose(ULTRA_DEEP_SLEEP_O) |-> $past(BUSY_FLAG_O) && cs_n)
        else $error("ultra sleep entered without entry delay");
    a_resume_busy: assert property ($fell(ULTRA_DEEP_SLEEP_O) |-> BUSY_FLAG_O)
        else $error("ultra sleep left without resume delay");
    a_reinit_near_busy: assert property (REINIT_O |-> ##[0:1]
        (BUSY_FLAG_O || $past(BUSY_FLAG_O) || $past(BUSY_FLAG_O, 2)))
        else $error("reinit pulse outside a delay");
    a_abort_after_busy: assert property (ABORT_PE_O |-> $past(BUSY_FLAG_O))
        else $error("abort pulse without abort delay");
    a_pass_in_gap: assert property (
        PASS_VALID_O |-> cs_n && $past(cs_n) && $past(cs_n, 2))
        else $error("opcode handed on inside a frame");
    a_ultra_silent: assert property (
        ULTRA_DEEP_SLEEP_O |-> !PASS_VALID_O && !ABORT_PE_O)
        else $error("command acted on in ultra sleep");
    a_busy_bounded: assert property (busy_run_q <= MAX_BUSY_CYC)
        else $error("busy flag held too long");
    ////////////////////////////////////////////////////////////
    c_ultra: cover property ($rose(ULTRA_DEEP_SLEEP_O));
    c_deep: cover property ($rose(DEEP_SLEEP_O));
    c_abort: cover property (ABORT_PE_O);
    c_reinit: cover property (REINIT_O);
endmodule : flash_link_asserts

// [verif/tb_top.sv]
`timescale 1ns/1ps
`include "flash_cmd_map.svh"
module tb_top;
    logic        clk, rst_n, sel, allow, prog, valid, hbusy, suspended_flag;
    logic        ready, done, ultra, deep, busy, reinit, abort_pe, pvalid;
    logic [15:0] data;
    logic [4:0]  nbits;
    logic [7:0]  popc;
    logic        m_ultra, m_deep;
    int          failures, tests_run, n_reinit, n_abort, n_pass, m_reinit, m_abort, armed;
    int          i, base;
    logic [7:0]  r;
    spi_link_if u_spi_link_if ();
    flash_powerdown_reset_terminate #(.ULTRA_ENTRY_DELAY_NS(80), .ULTRA_RESUME_DELAY_NS(160),
        .SOFT_RESET_DELAY_NS(400), .ABORT_DELAY_NS(400)) u_flash_powerdown_reset_terminate (
        .CORE_CLK_I(clk), .RST_N_I(rst_n), .LINK(u_spi_link_if.dev),
        .DEEP_SLEEP_SELECT_I(sel), .ABORT_CMD_ALLOW_I(allow), .PROG_BUSY_I(prog),
        .ULTRA_DEEP_SLEEP_O(ultra), .DEEP_SLEEP_O(deep), .BUSY_FLAG_O(busy),
        .REINIT_O(reinit), .ABORT_PE_O(abort_pe), .PASS_VALID_O(pvalid), .PASS_OPCODE_O(popc));
    spi_cmd_host u_spi_cmd_host (.CORE_CLK_I(clk), .RST_N_I(rst_n), .LINK(u_spi_link_if.host),
        .CMD_VALID_I(valid), .CMD_READY_O(ready), .CMD_DATA_I(data), .CMD_NBITS_I(nbits),
        .BUSY_FLAG_I(hbusy), .SUSPENDED_FLAG_I(suspended_flag), .DONE_O(done));
    flash_link_asserts #(.MAX_BUSY_CYC(52)) u_flash_link_asserts (.CORE_CLK_I(clk),
        .RST_N_I(rst_n), .cs_n(u_spi_link_if.cs_n), .sclk(u_spi_link_if.sclk),
        .si(u_spi_link_if.si), .ULTRA_DEEP_SLEEP_O(ultra), .DEEP_SLEEP_O(deep),
        .BUSY_FLAG_O(busy), .REINIT_O(reinit), .ABORT_PE_O(abort_pe), .PASS_VALID_O(pvalid));
    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Pulses are counted at the falling edge so the count never races the flops.
    always @(negedge clk) begin
        if (reinit === 1'b1) n_reinit++;
        if (abort_pe === 1'b1) n_abort++;
        if (pvalid === 1'b1) n_pass++;
    end
    initial begin
        #400000;
        failures++;
        final_report();
    end
    ////////////////////////////////////////////////////////////
    task automatic final_report();
        if (failures == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic model(input logic [15:0] d, input logic [4:0] n);
        logic [7:0] op;
        op = d[15:8];
        if (n % 8 != 0) armed = 0;
        else if (m_ultra) begin
            if (op == `OP_RESUME) begin
                m_ultra = 1'b0;
                m_reinit++;
            end
        end else if (op == `OP_RESET_ENABLE) armed = 1;
        else begin
            if (op == `OP_RESET_DEVICE && armed == 1) begin
                m_reinit++;
                m_deep = 1'b0;
            end else if (m_deep) begin
                if (op == `OP_RESUME) m_deep = 1'b0;
            end else if ((op == `OP_ULTRA_SLEEP || op == `OP_DEEP_SLEEP) && !prog) begin
                if (op == `OP_DEEP_SLEEP && sel) m_deep = 1'b1;
                else m_ultra = 1'b1;
            end else if (op == `OP_ABORT && allow && n == 16 && d[7:0] == `ABORT_CONFIRM)
                m_abort++;
            armed = 0;
        end
    endtask : model
    task automatic settle(input logic [15:0] d, input logic [4:0] n);
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 100) begin
            @(negedge clk);
            k++;
        end
        // The closing pulse shares its cycle with busy falling; let the counters take it.
        @(negedge clk);
        model(d, n);
        chk({ultra, deep, busy}, {m_ultra, m_deep, 1'b0});
        chk(n_reinit, m_reinit);
        chk(n_abort, m_abort);
    endtask : settle
    task automatic send(input logic [15:0] d, input logic [4:0] n, input bit upd);
        int k;
        @(posedge clk);
        valid <= 1'b1;
        data <= d;
        nbits <= n;
        k = 0;
        @(negedge clk);
        while (ready !== 1'b1 && k < 50) begin
            @(negedge clk);
            k++;
        end
        @(posedge clk);
        valid <= 1'b0;
        k = 0;
        @(negedge clk);
        while (done !== 1'b1 && k < 200) begin
            @(negedge clk);
            k++;
        end
        chk(k < 200, 1'b1);
        if (upd) settle(d, n);
    endtask : send
    task automatic refuse(input logic [15:0] d, input logic [4:0] n, input logic b,
                          input logic s);
        @(posedge clk);
        hbusy <= b;
        suspended_flag <= s;
        data <= d;
        nbits <= n;
        valid <= 1'b1;
        repeat (4) @(negedge clk);
        chk({ready, u_spi_link_if.cs_n}, 2'b01);
        @(posedge clk);
        valid <= 1'b0;
        hbusy <= 1'b0;
        suspended_flag <= 1'b0;
    endtask : refuse
    ////////////////////////////////////////////////////////////
    initial begin
        {rst_n, sel, allow, prog, valid, hbusy, suspended_flag, data, nbits} = '0;
        {failures, tests_run, n_reinit, n_abort, n_pass, m_reinit, m_abort, armed} = '0;
        {m_ultra, m_deep} = 2'b00;
        void'($urandom(41056));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk({ultra, deep, busy}, 3'b000);
        send(16'h7900, 5'd8, 1);
        send(16'h6600, 5'd8, 1);
        send(16'hf0d0, 5'd16, 1);
        send(16'h9900, 5'd8, 1);
        send(16'hab00, 5'd12, 1);
        send(16'hab00, 5'd8, 1);
        send(16'h7955, 5'd16, 1);
        send(16'hab00, 5'd8, 1);
        send(16'h7900, 5'd9, 1);
        @(posedge clk);
        sel <= 1'b1;
        send(16'hb900, 5'd8, 1);
        send(16'hab00, 5'd8, 1);
        send(16'hb900, 5'd8, 1);
        send(16'h6600, 5'd8, 1);
        send(16'h9900, 5'd8, 1);
        @(posedge clk);
        sel <= 1'b0;
        send(16'hb900, 5'd8, 1);
        send(16'hab00, 5'd8, 1);
        @(posedge clk);
        prog <= 1'b1;
        send(16'h7900, 5'd8, 1);
        send(16'hb900, 5'd8, 1);
        @(posedge clk);
        prog <= 1'b0;
        send(16'h6600, 5'd8, 1);
        send(16'h9900, 5'd8, 1);
        send(16'h6600, 5'd8, 1);
        send(16'h0500, 5'd8, 1);
        send(16'h9900, 5'd8, 1);
        send(16'h6600, 5'd12, 1);
        send(16'h9900, 5'd8, 1);
        send(16'hf0d0, 5'd16, 1);
        @(posedge clk);
        allow <= 1'b1;
        send(16'hf0d1, 5'd16, 1);
        send(16'hf0d0, 5'd12, 1);
        // The second frame lands inside the abort delay and must be dropped.
        @(posedge clk);
        prog <= 1'b1;
        send(16'hf0d0, 5'd16, 0);
        // Program busy is dropped so that only the abort delay can refuse this frame.
        @(posedge clk);
        prog <= 1'b0;
        send(16'h7900, 5'd8, 0);
        settle(16'hf0d0, 5'd16);
        base = n_pass;
        for (i = 0; i < 6; i++) begin
            do r = 8'($urandom);
            while (r inside {`OP_ULTRA_SLEEP, `OP_DEEP_SLEEP, `OP_RESUME, `OP_RESET_ENABLE,
                             `OP_RESET_DEVICE, `OP_ABORT});
            send({r, 8'h00}, 5'd8, 1);
            chk(popc, r);
        end
        chk(n_pass - base, 6);
        refuse(16'h7900, 5'd8, 1'b1, 1'b0);
        refuse(16'hb900, 5'd8, 1'b1, 1'b0);
        refuse(16'h6600, 5'd8, 1'b1, 1'b0);
        refuse(16'h6600, 5'd8, 1'b0, 1'b1);
        refuse(16'h0500, 5'd0, 1'b0, 1'b0);
        refuse(16'h0500, 5'd17, 1'b0, 1'b0);
        send(16'h7900, 5'd8, 1);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        {m_ultra, m_deep} = 2'b00;
        armed = 0;
        @(negedge clk);
        chk({ultra, deep, busy}, 3'b000);
        send(16'h7900, 5'd8, 1);
        final_report();
    end
endmodule : tb_top
